// >>> rtl/fspm_mapper.v
// Flash self-programming sequencer and address mapper
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "fspm_map.vh"
module fspm_mapper (
  input  wire        pclk,              // 25 MHz clock
  input  wire        presetn,           // Async reset, active low
  input  wire        psel,              // APB select
  input  wire        penable,           // APB enable
  input  wire        pwrite,            // APB direction
  input  wire [11:0] paddr,             // APB byte address
  input  wire [31:0] pwdata,            // APB write data
  output reg  [31:0] prdata,            // APB read data
  output reg         pready,            // APB ready
  output reg         pslverr,           // APB error
  input  wire        rc_tick_pin,       // RC oscillator tick, async
  input  wire        eeprom_write_pending, // Eeprom write busy, async
  input  wire [1:0]  boot_region_size_sel, // Boot size fuses, async
  output reg         flash_req_q,       // Flash array operation pulse
  output reg  [2:0]  flash_op_q,        // 1 erase, 2 write, 3 lock, 4 load
  output reg  [6:0]  flash_page_q,      // Page number to array
  output reg  [4:0]  flash_word_q,      // Word within page to array
  output reg  [15:0] flash_data_q,      // Word data to array
  output reg         fetch_stall_q      // Core fetch held off
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Boot region start word from size code
  function [11:0] boot_start;
    input [1:0] sz;
    begin
      if (sz == 2'h3)
        boot_start = 12'hF80;
      else if (sz == 2'h2)
        boot_start = 12'hF00;
      else if (sz == 2'h1)
        boot_start = 12'hE00;
      else
        boot_start = 12'hC00;
    end
  endfunction
  // True when the word lies in the concurrent read region
  function in_concurrent;
    input [11:0] a;
    begin
      in_concurrent = (a < `FSPM_HALTING_READ_REGION_START);
    end
  endfunction
  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam integer TICK_MIN =
    (`FSPM_TMIN_US * `FSPM_RC_KHZ + 999) / 1000;
  localparam integer TICK_MAX =
    (`FSPM_TMAX_US * `FSPM_RC_KHZ) / 1000;
  // Midpoint leaves margin for oscillator tolerance both ways
  localparam integer TICK_USE = (TICK_MIN + TICK_MAX) / 2;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ARM  = 2'h1;
  localparam [1:0] ST_RUN  = 2'h2;
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg  [2:0] tick_s1_q;                 // Tick sync stage 1
  reg  [2:0] tick_s2_q;                 // Tick sync stage 2 plus edge
  reg  [1:0] ee_s_q;                    // Eeprom pending sync
  reg  [1:0] bsz_s1_q;                  // Boot size stage 1
  reg  [1:0] bsz_s2_q;                  // Boot size stage 2
  wire       rc_tick;                   // Clean tick pulse
  // Only stage two and later feed logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_s1_q <= 3'h0;
      tick_s2_q <= 3'h0;
      ee_s_q    <= 2'h0;
      bsz_s1_q  <= 2'h0;
      bsz_s2_q  <= `FSPM_BOOT_REGION_SIZE_SEL_RST;
    end else begin
      tick_s1_q <= {2'h0, rc_tick_pin};
      tick_s2_q <= {tick_s2_q[1:0], tick_s1_q[0]};
      ee_s_q    <= {ee_s_q[0], eeprom_write_pending};
      bsz_s1_q  <= boot_region_size_sel;
      bsz_s2_q  <= bsz_s1_q;
    end
  end
  assign rc_tick = tick_s2_q[0] & ~tick_s2_q[1];
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg  [4:0]  cmd_q;                    // Armed command bits
  reg  [1:0]  st_q;                     // Sequencer state
  reg  [2:0]  arm_q;                    // Arm window count
  reg  [15:0] ptr_q;                    // Pointer register
  reg  [15:0] data_q;                   // Word data register
  reg         busy_region_flag;         // Concurrent region busy
  reg  [11:0] fetch_addr_q;             // Core fetch word address
  reg  [2:0]  run_op_q;                 // Operation being timed
  wire        tmr_busy;                 // Timer running
  wire        tmr_done;                 // Timer finished
  wire        wr_acc;                   // Write access phase
  wire        store;                    // Store instruction issued
  wire        cmd_ok;                   // Legal command code
  wire [6:0]  page_number_field;        // Pointer page bits
  wire [4:0]  word_in_page_field;       // Pointer word bits
  wire        store_cmd_enable;         // Enable bit view
  wire [11:0] boot_loader_region;       // Boot region start
  wire [11:0] load_word_addr;           // Word for byte reads
  assign wr_acc = psel & penable & pwrite;
  assign store  = wr_acc && (paddr == `FSPM_OFS_CTRL) &&
                  pwdata[`FSPM_BIT_STORE];
  assign cmd_ok = (pwdata[4:0] == `FSPM_CMD_LOAD)  ||
                  (pwdata[4:0] == `FSPM_CMD_ERASE) ||
                  (pwdata[4:0] == `FSPM_CMD_WRITE) ||
                  (pwdata[4:0] == `FSPM_CMD_LOCK)  ||
                  (pwdata[4:0] == `FSPM_CMD_REEN);
  // Bits 15:13 never reach any address
  assign page_number_field  = ptr_q[12:6];
  assign word_in_page_field = ptr_q[5:1];
  assign load_word_addr     = ptr_q[12:1];
  assign store_cmd_enable   = cmd_q[`FSPM_BIT_EN];
  assign boot_loader_region = boot_start(bsz_s2_q);
  // ----------------------------------------------------------------
  // Timer instance
  // ----------------------------------------------------------------
  fspm_timer #(
    .TICKS   (TICK_USE)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (st_q == ST_RUN && !tmr_busy && !tmr_done),
    .rc_tick (rc_tick),
    .busy_q  (tmr_busy),
    .done_q  (tmr_done)
  );
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Reset stops new commands and also clears a running timer;
  // the timer shares presetn with this sequencer, so both
  // restart from idle together when reset is released.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q            <= 5'h00;
      st_q             <= ST_IDLE;
      arm_q            <= 3'h0;
      busy_region_flag <= 1'b0;
      run_op_q         <= 3'h0;
      flash_req_q      <= 1'b0;
      flash_op_q       <= 3'h0;
      flash_page_q     <= 7'h00;
      flash_word_q     <= 5'h00;
      flash_data_q     <= 16'h0000;
    end else begin
      flash_req_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // Eeprom write blocks arming
          if (wr_acc && paddr == `FSPM_OFS_CTRL && cmd_ok &&
              !ee_s_q[1]) begin
            cmd_q <= pwdata[4:0];
            arm_q <= `FSPM_ARM_CYCLES;
            st_q  <= ST_ARM;
          end
        end
        ST_ARM: begin
          if (store) begin
            flash_page_q <= page_number_field;
            flash_word_q <= word_in_page_field;
            flash_data_q <= data_q;
            if (cmd_q == `FSPM_CMD_LOAD) begin
              flash_req_q      <= 1'b1;
              flash_op_q       <= 3'h4;
              busy_region_flag <= 1'b0;
              cmd_q            <= 5'h00;
              st_q             <= ST_IDLE;
            end else if (cmd_q == `FSPM_CMD_REEN) begin
              busy_region_flag <= 1'b0;
              cmd_q            <= 5'h00;
              st_q             <= ST_IDLE;
            end else begin
              flash_req_q <= 1'b1;
              if (cmd_q == `FSPM_CMD_ERASE) begin
                flash_op_q <= 3'h1;
                run_op_q   <= 3'h1;
              end else if (cmd_q == `FSPM_CMD_WRITE) begin
                flash_op_q <= 3'h2;
                run_op_q   <= 3'h2;
              end else begin
                flash_op_q <= 3'h3;
                run_op_q   <= 3'h3;
              end
              if (cmd_q != `FSPM_CMD_LOCK &&
                  in_concurrent({page_number_field, 5'h00}))
                busy_region_flag <= 1'b1;
              st_q <= ST_RUN;
            end
          end else if (arm_q == 3'h1) begin
            cmd_q <= 5'h00;
            st_q  <= ST_IDLE;
          end else begin
            arm_q <= arm_q - 3'h1;
          end
        end
        ST_RUN: begin
          // Enable stays set until completion
          if (tmr_done) begin
            cmd_q    <= 5'h00;
            run_op_q <= 3'h0;
            st_q     <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Pointer, data, fetch address and stall
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q         <= 16'h0000;
      data_q        <= 16'h0000;
      fetch_addr_q  <= 12'h000;
      fetch_stall_q <= 1'b0;
    end else begin
      if (wr_acc && paddr == `FSPM_OFS_PTR)
        ptr_q <= pwdata[15:0];
      if (wr_acc && paddr == `FSPM_OFS_DATA)
        data_q <= pwdata[15:0];
      if (wr_acc && paddr == `FSPM_OFS_FETCH)
        fetch_addr_q <= pwdata[11:0];
      // Only concurrent region fetches while erase/write of a concurrent page; all fetches for a halting page
      fetch_stall_q <= (st_q == ST_RUN) &&
                       (run_op_q != 3'h3) &&
                       (in_concurrent(fetch_addr_q) ||
                        !in_concurrent({flash_page_q, 5'h00}));
    end
  end
  // ----------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped address
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        if (paddr == `FSPM_OFS_CTRL)
          prdata <= {25'h0, busy_region_flag, 1'b0, cmd_q};
        else if (paddr == `FSPM_OFS_PTR)
          prdata <= {16'h0, ptr_q};
        else if (paddr == `FSPM_OFS_DATA)
          prdata <= {16'h0, data_q};
        else if (paddr == `FSPM_OFS_STATUS)
          prdata <= {28'h0, ptr_q[0], ee_s_q[1], tmr_busy,
                     store_cmd_enable};
        else if (paddr == `FSPM_OFS_MAP)
          prdata <= {8'h0, load_word_addr, boot_loader_region};
        else if (paddr == `FSPM_OFS_FETCH)
          prdata <= {20'h0, fetch_addr_q};
        else
          pslverr <= 1'b1;
      end
    end
  end
endmodule // fspm_mapper
`default_nettype wire

// >>> rtl/fspm_map.vh
// Constants for the flash self-programming mapper
`ifndef FSPM_MAP_VH
`define FSPM_MAP_VH
// ------------------------------------------------------------------
// APB register offsets (byte addresses)
// ------------------------------------------------------------------
`define FSPM_OFS_CTRL    12'h000
`define FSPM_OFS_PTR     12'h004
`define FSPM_OFS_DATA    12'h008
`define FSPM_OFS_STATUS  12'h00C
`define FSPM_OFS_MAP     12'h010
`define FSPM_OFS_FETCH   12'h014
// ------------------------------------------------------------------
// Control register field positions
// ------------------------------------------------------------------
`define FSPM_BIT_EN      0
`define FSPM_BIT_ERS     1
`define FSPM_BIT_WRT     2
`define FSPM_BIT_LCK     3
`define FSPM_BIT_REEN    4
`define FSPM_BIT_BUSY    6
`define FSPM_BIT_STORE   8
// ------------------------------------------------------------------
// Low five bits command codes
// ------------------------------------------------------------------
`define FSPM_CMD_LOAD    5'h01
`define FSPM_CMD_ERASE   5'h03
`define FSPM_CMD_WRITE   5'h05
`define FSPM_CMD_LOCK    5'h09
`define FSPM_CMD_REEN    5'h11
// ------------------------------------------------------------------
// Map, timing and reset values
// ------------------------------------------------------------------
`define FSPM_HALTING_READ_REGION_START  12'hC00
`define FSPM_ARM_CYCLES  3'h4
`define FSPM_RC_KHZ      1000
`define FSPM_TMIN_US     3700
`define FSPM_TMAX_US     4500
`define FSPM_BOOT_REGION_SIZE_SEL_RST  2'h0
`endif

// >>> rtl/fspm_timer.v
// Programming timer clocked by pclk, counting calibrated RC oscillator ticks
`timescale 1ns/100ps
`default_nettype none
`include "fspm_map.vh"
module fspm_timer #(
  parameter integer TICKS = 3700        // Oscillator ticks per operation
) (
  input  wire        pclk,              // System clock
  input  wire        presetn,           // Async reset, active low
  input  wire        start,             // Begin a timed operation
  input  wire        rc_tick,           // RC oscillator tick pulse
  output reg         busy_q,            // Operation under way
  output reg         done_q             // One-cycle end pulse
);
  // ----------------------------------------------------------------
  // Tick counter
  // ----------------------------------------------------------------
  reg [15:0] cnt_q;                     // Ticks elapsed
  // Counts oscillator ticks only, so pclk rate has no effect
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        cnt_q  <= 16'h0000;
        busy_q <= 1'b1;
      end else if (busy_q && rc_tick) begin
        if (cnt_q == TICKS[15:0] - 16'h0001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule // fspm_timer
`default_nettype wire

// >>> tb/fspm_mapper_chk.sv
// Port-level checker for the flash self-programming mapper
`timescale 1ns/100ps
`default_nettype none
`include "fspm_map.vh"
module fspm_mapper_chk (
  input wire logic        pclk,                 // Bus clock
  input wire logic        presetn,              // Async reset, active low
  input wire logic        psel,                 // APB select
  input wire logic        penable,              // APB enable
  input wire logic        pwrite,               // APB direction
  input wire logic [11:0] paddr,                // APB address
  input wire logic [31:0] pwdata,               // APB write data
  input wire logic [31:0] prdata,               // APB read data
  input wire logic        pready,               // APB ready
  input wire logic        pslverr,              // APB error
  input wire logic        rc_tick_pin,          // Oscillator tick
  input wire logic        eeprom_write_pending, // Eeprom busy
  input wire logic [1:0]  boot_region_size_sel, // Boot size code
  input wire logic        flash_req_q,          // Array request
  input wire logic [2:0]  flash_op_q,           // Array operation
  input wire logic [6:0]  flash_page_q,         // Array page
  input wire logic [4:0]  flash_word_q,         // Array word
  input wire logic [15:0] flash_data_q,         // Array data
  input wire logic        fetch_stall_q         // Fetch held off
);
  // ----------------------------------------------------------------
  // Helper: last pointer word written, to judge the array address
  // ----------------------------------------------------------------
  logic [15:0] ptr_q;                           // Shadow pointer
  wire acc_w = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= 16'h0000;
    end else if (acc_w && paddr == `FSPM_OFS_PTR) begin
      ptr_q <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------------
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence erase_cmd_s;
    acc_w && paddr == `FSPM_OFS_CTRL && !eeprom_write_pending &&
      pwdata[4:0] == `FSPM_CMD_ERASE && !pwdata[`FSPM_BIT_STORE];
  endsequence
  sequence store_s;
    acc_w && paddr == `FSPM_OFS_CTRL && pwdata[`FSPM_BIT_STORE];
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_unmapped_a: assert property
    (setup_s and paddr > `FSPM_OFS_FETCH |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  req_pulse_a: assert property (flash_req_q |=> !flash_req_q)
    else $error("array request longer than one cycle");
  req_op_legal_a: assert property
    (flash_req_q |-> flash_op_q inside {3'h1, 3'h2, 3'h3, 3'h4})
    else $error("array request with bad operation");
  req_page_map_a: assert property
    (flash_req_q && flash_op_q != 3'h3 |-> flash_page_q == ptr_q[12:6])
    else $error("page number not from pointer");
  req_word_map_a: assert property
    (flash_req_q && flash_op_q == 3'h4 |-> flash_word_q == ptr_q[5:1])
    else $error("word number not from pointer");
  armed_erase_go_a: assert property
    (erase_cmd_s ##3 store_s |-> ##1 (flash_req_q && flash_op_q == 3'h1))
    else $error("armed erase did not start");
endmodule // fspm_mapper_chk
`default_nettype wire

// >>> tb/fspm_rc_model.sv
// Calibrated oscillator stand-in driving the tick pin
`timescale 1ns/100ps
`default_nettype none
module fspm_rc_model #(
  parameter integer HALF_NS = 80  // Fast rate keeps runs short
) (
  output var logic rc_tick_pin    // Free-running tick
);
  // Free running, phase unrelated to the bus clock; counts stay in ticks
  initial begin
    rc_tick_pin = 1'b0;
    #13;
    forever #HALF_NS rc_tick_pin = ~rc_tick_pin;
  end
endmodule // fspm_rc_model
`default_nettype wire

// >>> tb/fspm_mapper_test.sv
// Self-checking testbench for the flash self-programming mapper
`timescale 1ns/100ps
`default_nettype none
`include "fspm_map.vh"
module fspm_mapper_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        rerr, rc_tick_pin, eeprom_write_pending, fetch_stall_q;
  logic [1:0]  boot_region_size_sel;
  logic        flash_req_q;
  logic [2:0]  flash_op_q;
  logic [6:0]  flash_page_q;
  logic [4:0]  flash_word_q;
  logic [15:0] flash_data_q;
  logic [30:0] req_v;                 // Last array request seen
  int          error_cnt = 0, compares = 0, req_n = 0, tick_n = 0;
  fspm_mapper u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rc_tick_pin,
    .eeprom_write_pending, .boot_region_size_sel, .flash_req_q,
    .flash_op_q, .flash_page_q, .flash_word_q, .flash_data_q,
    .fetch_stall_q);
  fspm_rc_model u_rc (.rc_tick_pin(rc_tick_pin));
  // Array request and oscillator monitors
  always @(posedge pclk) begin
    if (flash_req_q === 1'b1) begin
      req_n <= req_n + 1;
      req_v <= {flash_op_q, flash_page_q, flash_word_q, flash_data_q};
    end
  end
  always @(posedge rc_tick_pin) tick_n <= tick_n + 1;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 1, 0);
  endtask
  // Command write then store inside the arming window
  task automatic go(input logic [4:0] c);
    apb(1, `FSPM_OFS_CTRL, {27'h0, c});
    apb(1, `FSPM_OFS_CTRL, {23'h0, 1'b1, 3'h0, c});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    apb(0, `FSPM_OFS_CTRL, 0);
    chk("ctrl", 0, rdat);
    apb(0, `FSPM_OFS_STATUS, 0);
    chk("status", 0, rdat);
    apb(0, 12'h020, 0);
    chk("unmapped err", 1, rerr);
    chk("unmapped data", 0, rdat);
    $display("test reset done");
  endtask
  task automatic t_map;
    for (int i = 0; i < 4; i++) begin
      boot_region_size_sel <= i[1:0];
      repeat (4) @(posedge pclk);
      apb(0, `FSPM_OFS_MAP, 0);
      chk("boot start", 32'h1000 - (32'd1024 >> i), rdat[11:0]);
    end
    apb(1, `FSPM_OFS_PTR, 32'h0000_EABD);
    apb(0, `FSPM_OFS_MAP, 0);
    chk("load addr", 32'h55E, rdat[23:12]);
    apb(0, `FSPM_OFS_STATUS, 0);
    chk("byte sel", 1, rdat[3]);
    $display("test map done");
  endtask
  task automatic t_load;
    int n;
    apb(1, `FSPM_OFS_PTR, 32'h0000_EA62);
    apb(1, `FSPM_OFS_DATA, 32'h0000_BEEF);
    n = req_n;
    go(`FSPM_CMD_LOAD);
    repeat (6) @(posedge pclk);
    chk("load req", n + 1, req_n);
    chk("load op", 4, req_v[30:28]);
    chk("load page", 7'h29, req_v[27:21]);
    chk("load word", 5'h11, req_v[20:16]);
    chk("load data", 16'hBEEF, req_v[15:0]);
    $display("test load done");
  endtask
  task automatic t_expire;
    int n;
    n = req_n;
    apb(1, `FSPM_OFS_CTRL, {27'h0, `FSPM_CMD_ERASE});
    repeat (8) @(posedge pclk);
    apb(1, `FSPM_OFS_CTRL, 32'h0000_0100);
    eeprom_write_pending <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, `FSPM_OFS_STATUS, 0);
    chk("ee pending", 1, rdat[2]);
    go(`FSPM_CMD_ERASE);
    eeprom_write_pending <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("no req", n, req_n);
    apb(0, `FSPM_OFS_STATUS, 0);
    chk("enable off", 0, rdat[0]);
    $display("test expire done");
  endtask
  task automatic t_erase;
    int n, k, t0, t1;
    apb(1, `FSPM_OFS_PTR, 32'h0000_0140);
    n = req_n;
    go(`FSPM_CMD_ERASE);
    t0 = tick_n;
    repeat (4) @(posedge pclk);
    chk("erase req", n + 1, req_n);
    chk("erase op", 1, req_v[30:28]);
    chk("erase page", 5, req_v[27:21]);
    apb(0, `FSPM_OFS_CTRL, 0);
    chk("busy set", 1, rdat[6]);
    apb(1, `FSPM_OFS_FETCH, 32'h100);
    repeat (3) @(posedge pclk);
    chk("stall low", 1, fetch_stall_q);
    apb(1, `FSPM_OFS_FETCH, 32'hC00);
    repeat (3) @(posedge pclk);
    chk("stall high", 0, fetch_stall_q);
    apb(0, `FSPM_OFS_STATUS, 0);
    chk("enable held", 1, rdat[0]);
    k = 0;
    do begin
      apb(0, `FSPM_OFS_STATUS, 0);
      k++;
    end while (rdat[0] === 1'b1 && k < 20000);
    t1 = tick_n - t0;
    chk("span", 1, t1 >= `FSPM_TMIN_US * `FSPM_RC_KHZ / 1000 &&
        t1 <= `FSPM_TMAX_US * `FSPM_RC_KHZ / 1000);
    apb(0, `FSPM_OFS_CTRL, 0);
    chk("busy kept", 1, rdat[6]);
    go(`FSPM_CMD_REEN);
    repeat (3) @(posedge pclk);
    apb(0, `FSPM_OFS_CTRL, 0);
    chk("busy clear", 0, rdat[6]);
    apb(1, `FSPM_OFS_FETCH, 32'h100);
    repeat (3) @(posedge pclk);
    chk("stall off", 0, fetch_stall_q);
    $display("test erase done");
  endtask
  task automatic t_prog;
    int n, k;
    apb(1, `FSPM_OFS_PTR, 32'h0000_1800);
    n = req_n;
    go(`FSPM_CMD_WRITE);
    repeat (4) @(posedge pclk);
    chk("write req", n + 1, req_n);
    chk("write op", 2, req_v[30:28]);
    chk("write page", 7'h60, req_v[27:21]);
    apb(0, `FSPM_OFS_CTRL, 0);
    chk("busy not set", 0, rdat[6]);
    repeat (3) @(posedge pclk);
    chk("halt stall", 1, fetch_stall_q);
    k = 0;
    do begin
      apb(0, `FSPM_OFS_STATUS, 0);
      k++;
    end while (rdat[0] === 1'b1 && k < 20000);
    chk("write end", 0, rdat[0]);
    go(`FSPM_CMD_LOCK);
    repeat (4) @(posedge pclk);
    chk("lock req", n + 2, req_n);
    chk("lock op", 3, req_v[30:28]);
    repeat (3) @(posedge pclk);
    chk("lock stall", 0, fetch_stall_q);
    k = 0;
    do begin
      apb(0, `FSPM_OFS_STATUS, 0);
      k++;
    end while (rdat[0] === 1'b1 && k < 20000);
    chk("lock end", 0, rdat[0]);
    $display("test prog done");
  endtask
  // Verdict and end of run
  task test_done;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Watchdog well beyond three timed operations plus bus traffic
  initial begin
    #3200000;
    error_cnt++;
    test_done;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    eeprom_write_pending = 1'b0;
    boot_region_size_sel = 2'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_map;
    t_load;
    t_expire;
    t_erase;
    t_prog;
    test_done;
  end
endmodule // fspm_mapper_test
bind fspm_mapper fspm_mapper_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rc_tick_pin,
  .eeprom_write_pending, .boot_region_size_sel, .flash_req_q, .flash_op_q,
  .flash_page_q, .flash_word_q, .flash_data_q, .fetch_stall_q);
`default_nettype wire
